/* core/qdac_consts.svh */
// Constants of the quad DAC serial load control block.
// Assumes inclusion by the package and the design files by bare name.
`ifndef QDAC_CONSTS_SVH
`define QDAC_CONSTS_SVH

`define QDAC_NCH        4
`define QDAC_DW         12
`define QDAC_WORD_W     16
`define QDAC_BUF_BIT    15
`define QDAC_PIN_W      6
// Pin positions in the synchroniser vector
`define QDAC_P_SCL      0
`define QDAC_P_SDA      1
`define QDAC_P_LOAD     2
`define QDAC_P_PD       3
`define QDAC_P_A0       4
`define QDAC_P_A1       5
// Upper five slave address bits; value is arbitrary
`define QDAC_ADDR_HI    5'h0c
`define QDAC_BYTE_BITS  4'h8
`define QDAC_BIT_ZERO   4'h0
`define QDAC_BIT_ONE    4'h1
`define QDAC_IDX_ADDR   2'h0
`define QDAC_IDX_PTR    2'h1
`define QDAC_IDX_HI     2'h2
`define QDAC_IDX_LO     2'h3
`define QDAC_ALL_CH     4'hf
`define QDAC_NO_CH      4'h0
`define QDAC_CODE_RST   12'h000
// Host-side limits, kept for reference by the bench
`define QDAC_SCL_MAX_KBPS   400
`define QDAC_T_LOAD_SU_NS   400
`define QDAC_SYS_CLK_NS     100

`endif

/* core/qdac_pkg.sv */
// Types of the quad DAC serial load control block.
// Assumes qdac_consts.svh is on the include path.
`include "qdac_consts.svh"

package qdac_pkg;

  typedef enum logic [1:0] {QD_IDLE, QD_RX, QD_ACK} qdac_st_t;

  typedef struct packed {
    logic [`QDAC_PIN_W-1:0] s1;
    logic [`QDAC_PIN_W-1:0] s2;
    logic [`QDAC_PIN_W-1:0] s3;
  } qdac_sync_t;

  typedef struct packed {
    qdac_st_t                              st;
    logic [3:0]                            bitcnt;
    logic [1:0]                            idx;
    logic [7:0]                            byte_sh;
    logic [`QDAC_WORD_W-1:0]               word_sh;
    logic [1:0]                            ch;
    logic                                  sda_low;
    logic [`QDAC_NCH-1:0][`QDAC_DW-1:0]    in_code;
    logic [`QDAC_NCH-1:0]                  in_buf;
    logic [`QDAC_NCH-1:0]                  pend;
    logic [`QDAC_NCH-1:0][`QDAC_DW-1:0]    dac_code;
    logic [`QDAC_NCH-1:0]                  dac_buf;
  } qdac_state_t;

endpackage : qdac_pkg

/* core/qdac_pin_sync.sv */
// Two-flop synchronisers and edge finders for all pin inputs.
// Assumes every input is asynchronous to sys_clk.
`timescale 1ns/1ns
`include "qdac_consts.svh"

module qdac_pin_sync
  import qdac_pkg::*;
(
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  // Raw pins
  input  wire logic [`QDAC_PIN_W-1:0] pin_raw,
  // Synchronised view
  output logic      [`QDAC_PIN_W-1:0] pin_lvl,
  output logic      [`QDAC_PIN_W-1:0] pin_rise,
  output logic      [`QDAC_PIN_W-1:0] pin_fall
);

  qdac_sync_t r, r_nxt;

  always_comb begin
    r_nxt    = r;
    r_nxt.s1 = pin_raw;
    r_nxt.s2 = r.s1;
    r_nxt.s3 = r.s2;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '1;
    end else begin
      r <= r_nxt;
    end
  end

  // Edges look only at the second and third stage, never the first
  genvar g;
  generate
    for (g = 0; g < `QDAC_PIN_W; g++) begin : g_edge
      assign pin_lvl[g]  = r.s2[g];
      assign pin_rise[g] = r.s2[g] & ~r.s3[g];
      assign pin_fall[g] = ~r.s2[g] & r.s3[g];
    end
  endgenerate

endmodule : qdac_pin_sync

/* core/qdac_ctrl.sv */
// Quad DAC digital control: two-wire slave, input and DAC registers.
// Assumes a bus master with an external pull-up on the data line and
// a serial clock far slower than sys_clk (25 samples per bit or more).
`timescale 1ns/1ns
`include "qdac_consts.svh"

// How it works
// - Load low copies input to DAC registers
// - One load pulse updates all pending channels
// - Word bit selects buffered reference per channel
// - Power-down low idles channels, outputs high-Z
// - Data bits shift into 16-bit register
// - Data line open-drain: pull low or release
// - Address bits 0,1 come from pins
// - DAC codes are unsigned straight binary
module qdac_ctrl
  import qdac_pkg::*;
(
  // Clock and reset
  input  wire logic                                 sys_clk,
  input  wire logic                                 nrst,
  // Two-wire link
  input  wire logic                                 scl,
  input  wire logic                                 sda_i,
  output logic                                      sda_o,
  output logic                                      sda_oe,
  // Control pins
  input  wire logic                                 load_dac_n,
  input  wire logic                                 power_down_n,
  input  wire logic                                 addr_pin_0,
  input  wire logic                                 addr_pin_1,
  // Analog side
  output logic      [`QDAC_NCH-1:0][`QDAC_DW-1:0]   dac_code,
  output logic      [`QDAC_NCH-1:0]                 ref_buf_en,
  output logic      [`QDAC_NCH-1:0]                 chan_pd,
  output logic      [`QDAC_NCH-1:0]                 out_hiz
);

  qdac_state_t              r, r_nxt;
  logic [`QDAC_PIN_W-1:0]   p_lvl;
  logic [`QDAC_PIN_W-1:0]   p_rise;
  logic [`QDAC_PIN_W-1:0]   p_fall;
  logic                     scl_hi;
  logic                     scl_up;
  logic                     scl_dn;
  logic                     sda_lv;
  logic                     start_c;
  logic                     stop_c;
  logic                     ld_low;
  logic                     pd_low;
  logic                     commit;
  logic [`QDAC_NCH-1:0]     commit_ch;

  function automatic logic addr_match(input logic [7:0] b,
                                      input logic a1,
                                      input logic a0);
    addr_match = (b[7:1] == {`QDAC_ADDR_HI, a1, a0});
  endfunction : addr_match

  qdac_pin_sync u_sync (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .pin_raw  ({addr_pin_1, addr_pin_0, power_down_n, load_dac_n,
                sda_i, scl}),
    .pin_lvl  (p_lvl),
    .pin_rise (p_rise),
    .pin_fall (p_fall)
  );

  assign scl_hi  = p_lvl[`QDAC_P_SCL];
  assign scl_up  = p_rise[`QDAC_P_SCL];
  assign scl_dn  = p_fall[`QDAC_P_SCL];
  assign sda_lv  = p_lvl[`QDAC_P_SDA];
  assign start_c = scl_hi && p_fall[`QDAC_P_SDA];
  assign stop_c  = scl_hi && p_rise[`QDAC_P_SDA];
  // A tied-low load pin is a plain level, so it simply keeps copying
  assign ld_low  = !p_lvl[`QDAC_P_LOAD];
  assign pd_low  = !p_lvl[`QDAC_P_PD];

  // A word is complete when the low data byte ends
  assign commit  = (r.st == QD_RX) && scl_dn &&
                   (r.bitcnt == `QDAC_BYTE_BITS) &&
                   (r.idx == `QDAC_IDX_LO);
  always_comb begin
    commit_ch = `QDAC_NO_CH;
    if (commit) begin
      commit_ch[r.ch] = 1'b1;
    end
  end

  always_comb begin
    r_nxt = r;
    if (start_c) begin
      r_nxt.st      = QD_RX;
      r_nxt.bitcnt  = `QDAC_BIT_ZERO;
      r_nxt.idx     = `QDAC_IDX_ADDR;
      r_nxt.sda_low = 1'b0;
    end else if (stop_c) begin
      r_nxt.st      = QD_IDLE;
      r_nxt.sda_low = 1'b0;
    end else begin
      case (r.st)
        QD_IDLE: begin
          r_nxt.sda_low = 1'b0;
        end
        QD_RX: begin
          if (scl_up && r.bitcnt != `QDAC_BYTE_BITS) begin
            r_nxt.byte_sh = {r.byte_sh[6:0], sda_lv};
            r_nxt.bitcnt  = r.bitcnt + `QDAC_BIT_ONE;
            if (r.idx[1]) begin
              r_nxt.word_sh = {r.word_sh[`QDAC_WORD_W-2:0], sda_lv};
            end
          end else if (scl_dn && r.bitcnt == `QDAC_BYTE_BITS) begin
            r_nxt.st      = QD_ACK;
            r_nxt.sda_low = 1'b1;
            case (r.idx)
              `QDAC_IDX_ADDR: begin
                // Reads are not served; they are left unanswered
                if (!addr_match(r.byte_sh, p_lvl[`QDAC_P_A1],
                                p_lvl[`QDAC_P_A0]) || r.byte_sh[0]) begin
                  r_nxt.st      = QD_IDLE;
                  r_nxt.sda_low = 1'b0;
                end
              end
              `QDAC_IDX_PTR: begin
                r_nxt.ch = r.byte_sh[1:0];
              end
              default: begin
              end
            endcase
          end
        end
        QD_ACK: begin
          if (scl_dn) begin
            r_nxt.st      = QD_RX;
            r_nxt.sda_low = 1'b0;
            r_nxt.bitcnt  = `QDAC_BIT_ZERO;
            // Further words go on to the same channel
            r_nxt.idx     = (r.idx == `QDAC_IDX_LO) ? `QDAC_IDX_HI
                                                    : r.idx + 2'h1;
          end
        end
        default: begin
          r_nxt.st      = QD_IDLE;
          r_nxt.sda_low = 1'b0;
        end
      endcase
    end

    for (int c = 0; c < `QDAC_NCH; c++) begin
      // Load copies only channels holding fresh data, all at once
      if (ld_low && r.pend[c]) begin
        r_nxt.dac_code[c] = r.in_code[c];
        r_nxt.dac_buf[c]  = r.in_buf[c];
        r_nxt.pend[c]     = 1'b0;
      end
      // A word landing with the load still wins and is copied next cycle
      if (commit_ch[c]) begin
        r_nxt.in_code[c] = r.word_sh[`QDAC_DW-1:0];
        r_nxt.in_buf[c]  = r.word_sh[`QDAC_BUF_BIT];
        r_nxt.pend[c]    = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  // The line is only ever pulled low or released
  assign sda_o      = 1'b0;
  assign sda_oe     = r.sda_low;
  assign dac_code   = r.dac_code;
  assign ref_buf_en = r.dac_buf;
  assign chan_pd    = pd_low ? `QDAC_ALL_CH : `QDAC_NO_CH;
  assign out_hiz    = pd_low ? `QDAC_ALL_CH : `QDAC_NO_CH;

  genvar g;
  generate
    for (g = 0; g < `QDAC_NCH; g++) begin : g_chk
      a_load_copies_code: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ld_low && r.pend[g] |=> dac_code[g] == $past(r.in_code[g]))
        else $error("DAC register missed its load");
      a_hold_no_load: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        !ld_low |=> $stable(dac_code[g]))
        else $error("DAC register changed without load");
    end
  endgenerate

  a_load_all_ch: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    ld_low && !commit ##1 ld_low |-> r.pend == `QDAC_NO_CH)
    else $error("Pending channel left after load");

  a_buf_select: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    commit |=> r.in_buf[$past(r.ch)] == $past(r.word_sh[`QDAC_BUF_BIT]))
    else $error("Reference buffer bit not taken");

  a_pd_hiz_all: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    chan_pd == ($past(power_down_n, 2) ? `QDAC_NO_CH : `QDAC_ALL_CH) &&
    out_hiz == chan_pd)
    else $error("Power-down not applied to all channels");

  a_shift_bit: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    r.st == QD_RX && scl_up && r.idx[1] && !start_c && !stop_c &&
    r.bitcnt != `QDAC_BYTE_BITS |=> r.word_sh[0] == $past(sda_lv))
    else $error("Data bit not shifted in");

  a_od_ack_only: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    sda_oe |-> sda_o == 1'b0 && r.st == QD_ACK)
    else $error("Data line driven outside acknowledge");

  a_addr_match: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    sda_oe && r.idx == `QDAC_IDX_ADDR |->
    addr_match(r.byte_sh, p_lvl[`QDAC_P_A1], p_lvl[`QDAC_P_A0]))
    else $error("Acknowledged a foreign address");

endmodule : qdac_ctrl

/* tb/qdac_host.sv */
// Two-wire bus master model driving the serial link of the DAC control.
// Assumes an external pull-up resolves the data line outside this model.
`timescale 1ns/1ns

module qdac_host (
  // Link
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda_wire
);
  // A bit lasts 2500 ns, so the master never exceeds 400 kbps
  localparam int T_SETUP = 600;
  localparam int T_LOW   = 700;
  localparam int T_HIGH  = 1200;
  localparam int T_HALF  = 600;

  // Idle bus: clock stands high, data left to the pull-up
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic start_cond();
    sda_pull = 1'b1;
    #T_SETUP scl = 1'b0;
  endtask : start_cond

  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #T_SETUP sda_pull = ~b[i];
      #T_LOW scl = 1'b1;
      #T_HIGH scl = 1'b0;
    end
    #T_SETUP sda_pull = 1'b0;
    #T_LOW scl = 1'b1;
    #T_HALF ack = ~sda_wire;
    #T_HALF scl = 1'b0;
  endtask : send_byte

  // Stop leaves 1900 ns after the last clock rise before load can rise
  task automatic stop_cond();
    #T_SETUP sda_pull = 1'b1;
    #T_LOW scl = 1'b1;
    #T_HALF sda_pull = 1'b0;
    #(T_SETUP + T_LOW);
  endtask : stop_cond
endmodule : qdac_host

/* tb/quad_dac_serial_load_control_tb_top.sv */
// Self-checking bench for the quad DAC serial load control.
// Assumes qdac_host as bus master and a pull-up on the data line.
`timescale 1ns/1ns
`include "qdac_consts.svh"

module quad_dac_serial_load_control_tb_top;
  logic              sys_clk, nrst, scl, sda_pull, sda_o, sda_oe;
  logic              load_dac_n, power_down_n, addr_pin_0, addr_pin_1;
  logic [3:0][11:0]  dac_code;
  logic [3:0]        ref_buf_en, chan_pd, out_hiz, pend, exp_buf, in_buf;
  logic [3:0][11:0]  exp_code, in_code;
  int                num_errors, checks_done;
  // Pull-up: low only while some party pulls
  wire sda_wire = ~(sda_pull | (sda_oe & ~sda_o));

  qdac_host i_host (.scl(scl), .sda_pull(sda_pull), .sda_wire(sda_wire));
  qdac_ctrl i_dut (.sys_clk(sys_clk), .nrst(nrst), .scl(scl),
    .sda_i(sda_wire), .sda_o(sda_o), .sda_oe(sda_oe),
    .load_dac_n(load_dac_n), .power_down_n(power_down_n),
    .addr_pin_0(addr_pin_0), .addr_pin_1(addr_pin_1),
    .dac_code(dac_code), .ref_buf_en(ref_buf_en), .chan_pd(chan_pd),
    .out_hiz(out_hiz));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk(string what, logic [47:0] seen, logic [47:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  function automatic logic [7:0] slave_addr(logic rd);
    return {`QDAC_ADDR_HI, addr_pin_1, addr_pin_0, rd};
  endfunction : slave_addr

  task automatic write_word(logic [1:0] ch, logic [15:0] w, bit two = 1'b0,
                            logic [15:0] w2 = 16'h0000);
    logic [7:0] b [4];
    logic       a;
    b = '{slave_addr(1'b0), {6'h00, ch}, w[15:8], w[7:0]};
    i_host.start_cond();
    foreach (b[i]) begin
      i_host.send_byte(b[i], a);
      chk("byte ack", a, 1'b1);
    end
    // A second word in the same frame goes on to the same channel
    if (two) begin
      i_host.send_byte(w2[15:8], a);
      chk("word2 hi ack", a, 1'b1);
      i_host.send_byte(w2[7:0], a);
      chk("word2 lo ack", a, 1'b1);
      w = w2;
    end
    i_host.stop_cond();
    in_code[ch] = w[11:0];
    in_buf[ch] = w[15];
    pend[ch] = 1'b1;
  endtask : write_word

  // Moves pending input words into the expected DAC registers
  task automatic commit_and_wait();
    for (int c = 0; c < 4; c++) begin
      if (pend[c]) begin
        exp_code[c] = in_code[c];
        exp_buf[c] = in_buf[c];
      end
    end
    pend = 4'h0;
    for (int i = 0; i < 8 && dac_code !== exp_code; i++) @(posedge sys_clk);
    #1 chk("dac_code", dac_code, exp_code);
    chk("ref_buf_en", ref_buf_en, exp_buf);
  endtask : commit_and_wait

  task automatic pulse_load();
    chk("dac_code held", dac_code, exp_code);
    @(posedge sys_clk) #1 load_dac_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 load_dac_n = 1'b1;
    commit_and_wait();
  endtask : pulse_load

  initial begin
    for (int i = 0; i < 60000; i++) @(posedge sys_clk);
    num_errors++;
    results();
  end

  initial begin
    logic a;
    {nrst, load_dac_n, power_down_n, addr_pin_0, addr_pin_1} = 5'b01100;
    {pend, exp_buf, in_buf, exp_code, in_code} = '0;
    void'($urandom(88));
    repeat (4) @(posedge sys_clk);
    #1 nrst = 1'b1;
    {addr_pin_1, addr_pin_0} = 2'($urandom);
    repeat (4) @(posedge sys_clk);
    chk("reset code", dac_code, 48'h0);
    chk("reset ref_buf_en", ref_buf_en, 4'h0);
    chk("reset sda_oe", sda_oe, 1'b0);
    chk("sda_o", sda_o, 1'b0);
    for (int c = 0; c < 4; c++) write_word(2'(c), 16'($urandom));
    pulse_load();
    $display("test all channels load done");
    // Boundary codes on two channels; the other two must not move
    write_word(2'h1, 16'hffff);
    write_word(2'h2, 16'h8abc, 1'b1, 16'h7000);
    pulse_load();
    $display("test partial load done");
    // Wrong address and read requests are refused
    for (int k = 0; k < 2; k++) begin
      i_host.start_cond();
      i_host.send_byte(slave_addr(k[0]) ^ {6'h00, ~k[0], 1'b0}, a);
      chk("refused ack", a, 1'b0);
      i_host.stop_cond();
    end
    chk("dac_code after refusal", dac_code, exp_code);
    $display("test refusal done");
    @(posedge sys_clk) #1 load_dac_n = 1'b0;
    for (int n = 0; n < 3; n++) begin
      write_word(2'($urandom), 16'($urandom));
      commit_and_wait();
    end
    @(posedge sys_clk) #1 load_dac_n = 1'b1;
    $display("test tied load done");
    for (int p = 0; p < 2; p++) begin
      @(posedge sys_clk) #1 power_down_n = p[0];
      repeat (3) @(posedge sys_clk);
      #1 chk("chan_pd", chan_pd, {4{~p[0]}});
      chk("out_hiz", out_hiz, {4{~p[0]}});
    end
    $display("test power-down done");
    results();
  end
endmodule : quad_dac_serial_load_control_tb_top
